//--- pkg/sdlp_if.sv
// Local request port joining user logic and the controller
`timescale 1ns/1ps
`default_nettype none
interface sdlp_if
  import sdlp_pkg::*;
  (input wire logic core_clk, input wire logic rst_n);
  logic readReq;
  logic writeReq;
  logic [SIZE_W-1:0] size;
  logic [ADDR_W-1:0] addr;
  logic ready;
  logic wdataReq;
  logic [DATA_W-1:0] wdata;
  logic [BE_W-1:0] byteEn;
  logic [DATA_W-1:0] rdata;
  logic rdataValid;
  logic refreshReq;
  logic refreshAck;
  logic initDone;
  modport ctrl (
    input core_clk, rst_n, readReq, writeReq, size, addr, wdata, byteEn,
    refreshReq,
    output ready, wdataReq, rdata, rdataValid, refreshAck, initDone
  );
  modport user (
    input core_clk, rst_n, ready, wdataReq, rdata, rdataValid, refreshAck,
    initDone,
    output readReq, writeReq, size, addr, wdata, byteEn, refreshReq
  );
endinterface
`default_nettype wire

//--- pkg/sdlp_pkg.sv
// Constants and types shared by both ends of the local request port
package sdlp_pkg;
  // ----------------------------------------
  // Widths and queue
  // ----------------------------------------
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int BE_W = DATA_W / 8;
  localparam int SIZE_W = 3;
  localparam int QUEUE_DEPTH = 4;
  localparam int WFIFO_DEPTH = 4;
  // ----------------------------------------
  // Local address field layout (cs|bank|row|col)
  // ----------------------------------------
  localparam int COL_W = 9;
  localparam int ROW_W = 12;
  localparam int BANK_W = 2;
  localparam int CS_W = 1;
  localparam int COL_LSB = 0;
  localparam int ROW_LSB = COL_LSB + COL_W;
  localparam int BANK_LSB = ROW_LSB + ROW_W;
  localparam int CS_LSB = BANK_LSB + BANK_W;
  // ----------------------------------------
  // Burst lengths
  // ----------------------------------------
  localparam logic [3:0] MEM_BL_DDR = 4'h8;
  localparam logic [3:0] MEM_BL_DDR2 = 4'h4;
  localparam logic [SIZE_W-1:0] MAX_SIZE_DDR = 3'h4;
  localparam logic [SIZE_W-1:0] MAX_SIZE_DDR2 = 3'h2;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int STARTUP_MS = 200;
  localparam int STARTUP_CYCLES = (STARTUP_MS * 1000000) / CLK_PERIOD_NS;
  localparam int DLL_WAIT_CYCLES = 200;
  localparam int CMD_GAP_CYCLES = 2;
  localparam int READ_LAT_CYCLES = 3;
  // ----------------------------------------
  // Memory commands and mode bits
  // ----------------------------------------
  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACTIVATE, CMD_READ, CMD_WRITE,
    CMD_PRECHARGE_ALL, CMD_AUTO_REFRESH, CMD_LOAD_MODE
  } sdlp_cmd_t;
  localparam logic [1:0] BA_MODE_REG = 2'h0;
  localparam logic [1:0] BA_EXT_MODE_REG = 2'h1;
  localparam int PRECHARGE_BIT_A10 = 10;
  localparam int PRECHARGE_BIT_A8 = 8;
  localparam int DLL_RESET_BIT = 8;
endpackage

//--- src/sdlp_ctrl.sv
// Controller end: request queue, refresh, init sequence, memory commands
`timescale 1ns/1ps
`default_nettype none
module sdlp_ctrl
  import sdlp_pkg::*;
#(
  parameter int STARTUP_CNT = STARTUP_CYCLES,
  parameter bit IS_DDR2 = 1'b0,
  parameter bit PRECHARGE_ON_A8 = 1'b0,
  parameter int REFRESH_INTERVAL = 390
) (
  // Local side
  sdlp_if.ctrl lp,
  // Memory command side
  output logic [2:0] memCmd,
  output logic [CS_W-1:0] memCs,
  output logic [BANK_W-1:0] memBank,
  output logic [ROW_W-1:0] memAddr,
  output logic memDqsToggle,
  output logic [DATA_W-1:0] memWdata,
  output logic [BE_W-1:0] memByteEn,
  input wire logic [DATA_W-1:0] memRdata
);
  localparam int QW = 1 + SIZE_W + ADDR_W;
  typedef enum logic [3:0] {
    ST_STARTUP, ST_PCH1, ST_EMR, ST_MR1, ST_DLLWAIT, ST_PCH2, ST_ARF1,
    ST_ARF2, ST_MR2, ST_IDLE, ST_ACT, ST_XFER, ST_REFRESH
  } sdlp_state_t;

  sdlp_state_t state_q;
  logic [31:0] timer_q;
  logic [31:0] refTimer_q;
  logic refPending_q;
  logic qInValid, qInReady, qOutValid, qPop;
  logic [QW-1:0] qInData, qOutData;
  logic [SIZE_W-1:0] beat_q;
  logic [3:0] dqsBeat_q;
  logic [ROW_W-1:0] openRow_q;
  logic rowOpen_q;
  logic [READ_LAT_CYCLES-1:0] rdPipe_q;
  logic wdReq_q;
  logic sizeOk;
  logic curWrite;
  logic [SIZE_W-1:0] curSize;
  logic [ADDR_W-1:0] curAddr;

  // Field extraction from the flat address
  function automatic logic [ROW_W-1:0] rowOf(logic [ADDR_W-1:0] a);
    return a[ROW_LSB +: ROW_W];
  endfunction

  // ----------------------------------------
  // Request queue
  // ----------------------------------------
  // legal size check
  assign sizeOk = (lp.size != '0) &&
    (lp.size <= (IS_DDR2 ? MAX_SIZE_DDR2 : MAX_SIZE_DDR));
  assign qInValid = lp.initDone && (lp.readReq || lp.writeReq) && sizeOk;
  assign qInData = {lp.writeReq, lp.size, lp.addr};
  assign lp.ready = lp.initDone && qInReady;
  assign {curWrite, curSize, curAddr} = qOutData;

  sdlp_fifo #(.WIDTH(QW), .DEPTH(QUEUE_DEPTH)) sdlp_fifo_inst (
    .core_clk(lp.core_clk), .rst_n(lp.rst_n),
    .inValid(qInValid), .inReady(qInReady), .inData(qInData),
    .outValid(qOutValid), .outReady(qPop), .outData(qOutData)
  );

  assign qPop = (state_q == ST_XFER) && (beat_q == curSize - 1'b1);

  // ----------------------------------------
  // Refresh scheduling
  // ----------------------------------------
  always_ff @(posedge lp.core_clk) begin
    if (!lp.rst_n) begin
      refTimer_q <= '0;
      refPending_q <= 1'b0;
    end else if (state_q == ST_REFRESH) begin
      refTimer_q <= '0;
      refPending_q <= 1'b0;
    end else begin
      refTimer_q <= refTimer_q + 1'b1;
      if (lp.initDone && refTimer_q >= 32'(REFRESH_INTERVAL)) begin
        refPending_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Main sequencer
  // ----------------------------------------
  always_ff @(posedge lp.core_clk) begin
    if (!lp.rst_n) begin
      state_q <= ST_STARTUP;
      timer_q <= '0;
      beat_q <= '0;
      rowOpen_q <= 1'b0;
      openRow_q <= '0;
    end else begin
      timer_q <= timer_q + 1'b1;
      unique case (state_q)
        ST_STARTUP: if (timer_q >= 32'(STARTUP_CNT - 1)) begin
          state_q <= ST_PCH1;
          timer_q <= '0;
        end
        ST_PCH1: state_q <= ST_EMR;
        ST_EMR: state_q <= ST_MR1;
        ST_MR1: begin
          state_q <= ST_DLLWAIT;
          timer_q <= '0;
        end
        ST_DLLWAIT: if (timer_q >= 32'(DLL_WAIT_CYCLES - 1)) begin
          state_q <= ST_PCH2;
        end
        ST_PCH2: state_q <= ST_ARF1;
        ST_ARF1: state_q <= ST_ARF2;
        ST_ARF2: state_q <= ST_MR2;
        ST_MR2: state_q <= ST_IDLE;
        ST_IDLE: begin
          beat_q <= '0;
          if (lp.refreshReq || refPending_q) begin
            state_q <= ST_REFRESH;
            rowOpen_q <= 1'b0;
          end else if (qOutValid) begin
            if (rowOpen_q && openRow_q == rowOf(curAddr)) begin
              state_q <= ST_XFER;
            end else begin
              state_q <= ST_ACT;
            end
          end
        end
        ST_ACT: begin
          state_q <= ST_XFER;
          rowOpen_q <= 1'b1;
          openRow_q <= rowOf(curAddr);
        end
        ST_XFER: begin
          beat_q <= beat_q + 1'b1;
          if (qPop) begin
            state_q <= ST_IDLE;
          end
        end
        ST_REFRESH: state_q <= ST_IDLE;
        default: state_q <= ST_STARTUP;
      endcase
    end
  end

  // ----------------------------------------
  // Memory command outputs
  // ----------------------------------------
  always_comb begin
    memCmd = CMD_NOP;
    memCs = curAddr[CS_LSB +: CS_W];
    memBank = curAddr[BANK_LSB +: BANK_W];
    memAddr = '0;
    unique case (state_q)
      ST_PCH1, ST_PCH2: begin
        memCmd = CMD_PRECHARGE_ALL;
        memAddr[PRECHARGE_ON_A8 ? PRECHARGE_BIT_A8 : PRECHARGE_BIT_A10] =
          1'b1;
      end
      ST_EMR: begin
        memCmd = CMD_LOAD_MODE;
        memBank = BA_EXT_MODE_REG;
      end
      ST_MR1, ST_MR2: begin
        memCmd = CMD_LOAD_MODE;
        memBank = BA_MODE_REG;
        memAddr[DLL_RESET_BIT] = (state_q == ST_MR1);
      end
      ST_ARF1, ST_ARF2, ST_REFRESH: memCmd = CMD_AUTO_REFRESH;
      ST_ACT: begin
        memCmd = CMD_ACTIVATE;
        memAddr = rowOf(curAddr);
      end
      ST_XFER: begin
        memCmd = curWrite ? CMD_WRITE : CMD_READ;
        memAddr = ROW_W'(curAddr[COL_LSB +: COL_W] + COL_W'(beat_q));
      end
      default: memCmd = CMD_NOP;
    endcase
  end

  // ----------------------------------------
  // Data handshakes
  // ----------------------------------------
  // acknowledge on each ST_REFRESH refresh; the two init refreshes (ST_ARF1, ST_ARF2) get none
  assign lp.refreshAck = (state_q == ST_REFRESH);
  always_ff @(posedge lp.core_clk) begin
    if (!lp.rst_n) begin
      lp.initDone <= 1'b0;
    end else if (state_q == ST_MR2) begin
      lp.initDone <= 1'b1;
    end
  end

  // write data requested each write beat
  assign lp.wdataReq = (state_q == ST_XFER) && curWrite;
  always_ff @(posedge lp.core_clk) begin
    if (!lp.rst_n) begin
      wdReq_q <= 1'b0;
      memWdata <= '0;
      memByteEn <= '0;
      rdPipe_q <= '0;
      lp.rdata <= '0;
      lp.rdataValid <= 1'b0;
      dqsBeat_q <= '0;
    end else begin
      wdReq_q <= lp.wdataReq;
      memWdata <= wdReq_q ? lp.wdata : '0;
      memByteEn <= wdReq_q ? lp.byteEn : '0;
      rdPipe_q <= {rdPipe_q[READ_LAT_CYCLES-2:0],
                   (state_q == ST_XFER) && !curWrite};
      lp.rdataValid <= rdPipe_q[READ_LAT_CYCLES-1];
      lp.rdata <= memRdata;
      if (lp.wdataReq && dqsBeat_q == '0) begin
        dqsBeat_q <= (IS_DDR2 ? MEM_BL_DDR2 : MEM_BL_DDR);
      end else if (dqsBeat_q != '0) begin
        dqsBeat_q <= dqsBeat_q - 1'b1;
      end
    end
  end
  assign memDqsToggle = (dqsBeat_q != '0);
endmodule // sdlp_ctrl
`default_nettype wire

//--- src/sdlp_fifo.sv
// Valid/ready FIFO with parameterised width and depth
`timescale 1ns/1ps
`default_nettype none
module sdlp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_q;
  logic [PW-1:0] rdPtr_q;
  logic [PW:0] count_q;
  logic push;
  logic pop;

  assign inReady = (count_q != (PW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData = mem[rdPtr_q];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == PW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == PW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
      end
      count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule // sdlp_fifo
`default_nettype wire

//--- src/sdlp_user.sv
// User end: issues requests, supplies write data, drives refresh
`timescale 1ns/1ps
`default_nettype none
module sdlp_user
  import sdlp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Local port
  sdlp_if.user lp,
  // User command side
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic cmdWrite,
  input wire logic [SIZE_W-1:0] cmdSize,
  input wire logic [ADDR_W-1:0] cmdAddr,
  // Write data source
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [DATA_W+BE_W-1:0] wrData,
  // Read data and status
  output logic [DATA_W-1:0] rdData,
  output logic rdValid,
  output logic initDone,
  // Refresh control
  input wire logic refreshWant,
  output logic refreshSeen
);
  logic holdValid_q;
  logic holdWrite_q;
  logic [SIZE_W-1:0] holdSize_q;
  logic [ADDR_W-1:0] holdAddr_q;
  logic bufValid;
  logic [DATA_W+BE_W-1:0] bufData;

  assign cmdReady = !holdValid_q || lp.ready;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      holdValid_q <= 1'b0;
      holdWrite_q <= 1'b0;
      holdSize_q <= '0;
      holdAddr_q <= '0;
    end else if (cmdReady) begin
      holdValid_q <= cmdValid;
      holdWrite_q <= cmdWrite;
      holdSize_q <= cmdSize;
      holdAddr_q <= cmdAddr;
    end
  end
  assign lp.readReq = holdValid_q && !holdWrite_q;
  assign lp.writeReq = holdValid_q && holdWrite_q;
  assign lp.size = holdSize_q;
  assign lp.addr = holdAddr_q;

  // write data staged in FIFO
  // Pop as each beat is asked, so every beat that finds the FIFO non-empty gets its own word; otherwise byteEn is zero
  sdlp_fifo #(.WIDTH(DATA_W + BE_W), .DEPTH(WFIFO_DEPTH)) sdlp_fifo_inst (
    .core_clk(core_clk), .rst_n(rst_n),
    .inValid(wrValid), .inReady(wrReady), .inData(wrData),
    .outValid(bufValid), .outReady(lp.wdataReq), .outData(bufData)
  );

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lp.wdata <= '0;
      lp.byteEn <= '0;
    end else begin
      if (lp.wdataReq) begin
        lp.wdata <= bufData[DATA_W+BE_W-1:BE_W];
        lp.byteEn <= bufValid ? bufData[BE_W-1:0] : '0;
      end
    end
  end

  assign lp.refreshReq = refreshWant;
  assign refreshSeen = lp.refreshAck;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdData <= '0;
      rdValid <= 1'b0;
      initDone <= 1'b0;
    end else begin
      rdData <= lp.rdata;
      rdValid <= lp.rdataValid;
      initDone <= lp.initDone;
    end
  end
endmodule // sdlp_user
`default_nettype wire

//--- tb/sdlp_port_monitor.sv
// Protocol checker on the local request port
`timescale 1ns/1ps
`default_nettype none
module sdlp_port_monitor
  import sdlp_pkg::*;
#(
  parameter int STARTUP_CNT = 10
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Requests
  input wire logic readReq,
  input wire logic writeReq,
  input wire logic [SIZE_W-1:0] size,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic ready,
  // Data, refresh, status
  input wire logic wdataReq,
  input wire logic rdataValid,
  input wire logic refreshReq,
  input wire logic refreshAck,
  input wire logic initDone
);
  // ------
  // Outstanding beats
  // ------
  logic [7:0] rCnt_q;
  logic [7:0] wCnt_q;
  logic [15:0] initCyc_q;
  logic legal;
  logic rdAcc;
  logic wrAcc;
  assign legal = size != 3'h0 && size <= MAX_SIZE_DDR;
  assign rdAcc = readReq && ready && legal;
  assign wrAcc = writeReq && ready && legal;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rCnt_q <= 8'h0;
      wCnt_q <= 8'h0;
    end else begin
      rCnt_q <= rCnt_q + (rdAcc ? 8'(size) : 8'h0) - 8'(rdataValid);
      wCnt_q <= wCnt_q + (wrAcc ? 8'(size) : 8'h0) - 8'(wdataReq);
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      initCyc_q <= 16'h0;
    end else if (initCyc_q != 16'hffff) begin
      initCyc_q <= initCyc_q + 16'h1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_hold;
    (readReq || writeReq) && !ready |=> $stable(addr) && $stable(size)
      && $stable(readReq) && $stable(writeReq);
  endproperty
  a_hold: assert property (p_hold)
    else $error("request changed while stalled");
  property p_rdcnt;
    rdataValid |-> rCnt_q != 8'h0;
  endproperty
  a_rdcnt: assert property (p_rdcnt)
    else $error("read word without accepted read");
  property p_wrcnt;
    wdataReq |-> wCnt_q != 8'h0;
  endproperty
  a_wrcnt: assert property (p_wrcnt)
    else $error("write data asked without write");
  property p_ackpulse;
    refreshAck |=> !refreshAck;
  endproperty
  a_ackpulse: assert property (p_ackpulse)
    else $error("refresh acknowledge not a pulse");
  property p_ackbound;
    $rose(refreshReq) && initDone |-> ##[0:20] refreshAck;
  endproperty
  a_ackbound: assert property (p_ackbound)
    else $error("refresh not served in time");
  property p_ackgap;
    refreshAck |-> !wdataReq;
  endproperty
  a_ackgap: assert property (p_ackgap)
    else $error("write beat during refresh");
  property p_donestay;
    initDone |=> initDone;
  endproperty
  a_donestay: assert property (p_donestay)
    else $error("init done dropped");
  property p_rdyinit;
    ready |-> initDone;
  endproperty
  a_rdyinit: assert property (p_rdyinit)
    else $error("ready before init done");
  property p_rdyfirst;
    $rose(initDone) |-> ready;
  endproperty
  a_rdyfirst: assert property (p_rdyfirst)
    else $error("queue not open after init");
  property p_init;
    $rose(initDone) |-> initCyc_q >= 16'(STARTUP_CNT + 200);
  endproperty
  a_init: assert property (p_init)
    else $error("init sequence too short");
  c_write: cover property (writeReq && ready);
  c_read: cover property (rdataValid);
  c_full: cover property (initDone && !ready);
  c_ack: cover property (refreshAck ##2 refreshAck);
endmodule // sdlp_port_monitor
`default_nettype wire

//--- tb/sdram_local_request_port_test.sv
// Bench joining user end and controller end
`timescale 1ns/1ps
`default_nettype none
module sdram_local_request_port_test
  import sdlp_pkg::*;
();
  localparam int STARTUP = 10;
  localparam int WBASE = 32'h00a50010;
  localparam logic [BE_W-1:0] WBE = 4'h5;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmdValid = 1'b0;
  logic cmdWrite = 1'b0;
  logic [SIZE_W-1:0] cmdSize = 3'h1;
  logic [ADDR_W-1:0] cmdAddr = 24'h0;
  logic wrValid = 1'b0;
  logic [DATA_W+BE_W-1:0] wrData = 36'hc3a5e17bf;
  logic refreshWant = 1'b0;
  logic [DATA_W-1:0] memRdata = 32'h0;
  logic cmdReady, wrReady, rdValid, initDone, refreshSeen, memDqsToggle;
  logic [2:0] memCmd;
  logic [CS_W-1:0] memCs;
  logic [BANK_W-1:0] memBank;
  logic [ROW_W-1:0] memAddr, memAddr2, pchA, pchA2;
  logic [ADDR_W-ROW_LSB-1:0] actA;
  logic [2:0] memCmd2;
  logic memDqsToggle2;
  logic [DATA_W-1:0] memWdata, rdData, wsum;
  logic [DATA_W-1:0] lastRd = '0;
  logic [BE_W-1:0] memByteEn;
  int error_cnt, n_tests, cycCnt, rdv, wdr, ack, dqs, acc;
  int rord, bsum, emr, wdr2, dqs2;
  sdlp_if lp (.core_clk, .rst_n);
  sdlp_if lp2 (.core_clk, .rst_n);
  sdlp_ctrl #(.STARTUP_CNT(STARTUP)) sdlp_ctrl_inst (.lp, .memCmd, .memCs,
    .memBank, .memAddr, .memDqsToggle, .memWdata, .memByteEn, .memRdata);
  // DDR2 controller with precharge on bit 8, driven by the bench
  sdlp_ctrl #(.STARTUP_CNT(STARTUP), .IS_DDR2(1'b1), .PRECHARGE_ON_A8(1'b1))
    sdlp_ctrl_inst2 (.lp(lp2), .memCmd(memCmd2), .memCs(), .memBank(),
    .memAddr(memAddr2), .memDqsToggle(memDqsToggle2), .memWdata(),
    .memByteEn(), .memRdata);
  sdlp_user sdlp_user_inst (.core_clk, .rst_n, .lp, .cmdValid, .cmdReady,
    .cmdWrite, .cmdSize, .cmdAddr, .wrValid, .wrReady, .wrData, .rdData,
    .rdValid, .initDone, .refreshWant, .refreshSeen);
  sdlp_port_monitor #(.STARTUP_CNT(STARTUP)) sdlp_port_monitor_inst (
    .core_clk, .rst_n, .readReq(lp.readReq), .writeReq(lp.writeReq),
    .size(lp.size), .addr(lp.addr), .ready(lp.ready),
    .wdataReq(lp.wdataReq), .rdataValid(lp.rdataValid),
    .refreshReq(lp.refreshReq), .refreshAck(lp.refreshAck),
    .initDone(lp.initDone));
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  // ------
  // Event counters
  // ------
  always @(negedge core_clk) memRdata <= memRdata + 32'h1;
  always @(posedge core_clk) begin
    rdv += rdValid;
    wdr += lp.wdataReq;
    ack += refreshSeen;
    dqs += memDqsToggle;
    acc += lp.ready && (lp.readReq || lp.writeReq);
    if (memCmd === CMD_ACTIVATE) actA <= {memCs, memBank, memAddr};
    wdr2 += lp2.wdataReq;
    dqs2 += memDqsToggle2;
    bsum += memByteEn;
    wsum += memWdata;
    if (memCmd === CMD_PRECHARGE_ALL) pchA <= memAddr;
    if (memCmd2 === CMD_PRECHARGE_ALL) pchA2 <= memAddr2;
    emr += (memCmd === CMD_LOAD_MODE) && (memBank === BA_EXT_MODE_REG);
    if (rdValid === 1'b1) begin
      rord += (rdData > lastRd);
      lastRd = rdData;
    end
    cycCnt++;
    if (cycCnt == 3000) begin
      error_cnt++;
      results();
    end
  end
  task automatic results();
    $display("errors=%0d tests=%0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic clr();
    @(negedge core_clk);
    {rdv, wdr, ack, dqs, acc, rord, bsum} = '0;
    wsum = '0;
  endtask
  task automatic cmd(input logic w, input logic [2:0] sz,
      input logic [23:0] a);
    int i;
    logic rdy;
    i = 0;
    @(negedge core_clk);
    cmdValid = 1'b1;
    cmdWrite = w;
    cmdSize = sz;
    cmdAddr = a;
    do begin
      #9;
      rdy = cmdReady;
      @(negedge core_clk);
      i++;
    end while (rdy !== 1'b1 && i < 60);
    cmdValid = 1'b0;
    chk(32'(rdy), 32'h1);
  endtask
  task automatic t_init();
    int i;
    for (i = 0; i < 400 && initDone !== 1'b1; i++) @(negedge core_clk);
    chk(32'(i >= STARTUP + 200), 32'h1);
    chk(lp.ready, 32'h1);
    chk(pchA, 32'h400);
    chk(pchA2, 32'h100);
    chk(emr, 32'd1);
  endtask
  task automatic t_ddr2();
    for (int s = 3; s >= 2; s--) begin
      wdr2 = 0;
      dqs2 = 0;
      @(negedge core_clk);
      lp2.writeReq = 1'b1;
      lp2.size = 3'(s);
      lp2.addr = 24'h000100;
      @(negedge core_clk);
      lp2.writeReq = 1'b0;
      repeat (20) @(negedge core_clk);
      chk(wdr2, (s == 2) ? 32'd2 : 32'd0);
      chk(dqs2, (s == 2) ? 32'(MEM_BL_DDR2) : 32'd0);
    end
  endtask
  task automatic t_reads();
    clr();
    for (int s = 1; s <= 4; s++) cmd(1'b0, 3'(s), 24'h000010);
    repeat (40) @(negedge core_clk);
    chk(rdv, 32'd10);
    chk(rord, 32'd10);
    clr();
    cmd(1'b0, 3'h0, 24'h000020);
    cmd(1'b0, 3'h5, 24'h000020);
    repeat (30) @(negedge core_clk);
    chk(rdv, 32'd0);
  endtask
  task automatic t_refresh();
    clr();
    refreshWant = 1'b1;
    for (int i = 0; i < 40 && ack < 2; i++) @(negedge core_clk);
    refreshWant = 1'b0;
    repeat (6) @(negedge core_clk);
    chk(ack, 32'd2);
  endtask
  task automatic fill_fifo(input int n);
    int got;
    got = 0;
    @(negedge core_clk);
    for (int c = 0; c < n + 4 && got < n; c++) begin
      wrValid = 1'b1;
      wrData = {32'(WBASE + got), WBE};
      #9;
      got += wrReady;
      @(negedge core_clk);
    end
    wrValid = 1'b0;
    chk(got, n);
    chk(wrReady, 32'(n < WFIFO_DEPTH));
  endtask
  task automatic t_write(input logic [2:0] sz, input logic [23:0] a);
    int n;
    n = int'(sz);
    fill_fifo(n);
    clr();
    cmd(1'b1, sz, a);
    repeat (30) @(negedge core_clk);
    chk(wdr, 32'(sz));
    chk(dqs, 32'(MEM_BL_DDR));
    chk(32'(actA), 32'(a[ADDR_W-1:ROW_LSB]));
    chk(wsum, 32'(n * WBASE + n * (n - 1) / 2));
    chk(bsum, 32'(n * int'(WBE)));
  endtask
  task automatic t_queue();
    clr();
    refreshWant = 1'b1;
    fork
      repeat (5) cmd(1'b0, 3'h1, 24'h000040);
      begin
        repeat (20) @(negedge core_clk);
        chk(acc, QUEUE_DEPTH);
        chk(lp.ready, 32'h0);
        refreshWant = 1'b0;
      end
    join
    repeat (40) @(negedge core_clk);
    chk(rdv, 32'd5);
  endtask
  initial begin
    {lp2.readReq, lp2.writeReq, lp2.refreshReq} = 3'h0;
    {lp2.wdata, lp2.byteEn} = '0;
    lp2.size = 3'h1;
    lp2.addr = '0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    t_init();
    t_ddr2();
    t_reads();
    t_refresh();
    t_write(3'h4, 24'h5a3e01);
    t_write(3'h1, 24'h5a3e07);
    t_queue();
    results();
  end
endmodule // sdram_local_request_port_test
`default_nettype wire
